/* common/port_tuning_regs.svh */
// offsets, field positions, reset values and masks of the port tuning bank
`ifndef PORT_TUNING_REGS_SVH
`define PORT_TUNING_REGS_SVH

`define OFS_TUNE_A          8'h80
`define OFS_TUNE_B          8'h84
`define OFS_RATE_RST        8'h88
`define OFS_TL_OPT          8'h8C

`define RST_TUNE_A          32'h000F_0000
`define RST_TUNE_B          32'h0000_0000
`define RST_RATE_RST        32'h3308_3333
`define RST_TL_OPT          32'h0079_1894

`define BIT_KEEP_CFG        11
`define BIT_RATE_CHANGE     30
`define BIT_GEN1_ONLY       31
`define BIT_FRAME_FORMAT    0
`define BIT_MW_OVERPASS     5
`define BIT_ORDER_DISABLE   6
`define LSB_ATTEMPTS        8
`define BIT_PORT_DISABLE    10
`define BIT_RESET_SELECT    11
`define LSB_RETRAIN_MIRROR  16

`define WMASK_RATE_RST      32'hC000_0000
`define WMASK_TL_OPT        32'h0000_0060
`define RSVD_TL_OPT         32'h4000_E000
`define PRE_ONLY_EEPROM     32'h0000_0040
`define STRAP_WAIT          2'h3

`endif

/* common/port_tuning_pkg.sv */
// types shared by the port tuning register bank
`default_nettype none
package port_tuning_pkg;

	// origin of a default-value preload
	typedef enum logic [1:0] {SRC_SMBUS, SRC_I2C, SRC_EEPROM} preload_src_t;

	// whole state of the bank
	typedef struct packed {
		logic [31:0] tune_a;
		logic [31:0] tune_b;
		logic [31:0] rate_rst;
		logic [31:0] tl_opt;
		logic        up_s1;
		logic        up_s2;
		logic        is_up;
		logic [1:0]  strap_cnt;
		logic [31:0] rdata;
		logic        rvalid;
		logic        cfg_reset;
		logic        reset_sel;
	} bank_state_t;

endpackage : port_tuning_pkg
`default_nettype wire

/* rtl/switch_port_tuning_csr_bank.sv */
// per-port phy tuning, link-rate and transaction-layer option registers
//
// Overview of operation
// RULE1: smbus, i2c or eeprom preload replaces defaults
// RULE2: 0x80 read-write word, reset 000F0000
// RULE3: 0x84 read-only word, upstream port only
// RULE4: 0x88 bits 29:0 read-only, reset 33083333
// RULE5: 0x88 bit 11 low resets config on link-down
// RULE6: rate change bit 30, gen1-only bit 31 writable
// RULE7: 0x8C option bits read-only with fixed resets
// RULE8: bit 5 overpass disable, upstream-only write
// RULE9: bit 6 stops relaxed ordering, eeprom-only preload
// RULE10: bits 9:8 give rate change attempt count
// RULE11: bit 10 disables the port
// RULE12: bit 11 reset select, upstream only
// RULE13: bits 23:16 mirror, bit 16 stops retrain
// RULE14: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "port_tuning_regs.svh"

module switch_port_tuning_csr_bank (
	input  wire logic        REF_CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        IS_UPSTREAM_I,
	input  wire logic        UP_LINK_DOWN_I,
	input  wire logic        CFG_WR_I,
	input  wire logic        CFG_RD_I,
	input  wire logic [7:0]  CFG_ADDR_I,
	input  wire logic [31:0] CFG_WDATA_I,
	input  wire logic [3:0]  CFG_BE_I,
	input  wire logic        PRE_WR_I,
	input  wire logic [1:0]  PRE_SRC_I,
	input  wire logic [7:0]  PRE_ADDR_I,
	input  wire logic [31:0] PRE_WDATA_I,
	output logic [31:0]      CFG_RDATA_O,
	output logic             CFG_RVALID_O,
	output logic             CFG_DATA_RESET_O,
	output logic             RATE_CHANGE_CONTROL_O,
	output logic             FIRST_GEN_ONLY_O,
	output logic             WRITE_OVERPASS_DISABLE_O,
	output logic             RELAXED_ORDER_DISABLE_O,
	output logic [1:0]       RATE_CHANGE_ATTEMPTS_O,
	output logic             PORT_DISABLE_O,
	output logic             RESET_SELECT_O,
	output logic             PHY_RETRAIN_DISABLE_O
);

	port_tuning_pkg::bank_state_t st_reg;
	port_tuning_pkg::bank_state_t st_next;
	logic [31:0]                  be_mask;
	logic                         cfg_ok;

	// byte lanes of a config write, blocked until the strap is taken
	assign be_mask = {{8{CFG_BE_I[3]}}, {8{CFG_BE_I[2]}}, {8{CFG_BE_I[1]}}, {8{CFG_BE_I[0]}}};
	assign cfg_ok  = CFG_WR_I && (st_reg.strap_cnt == 2'h0);

	// next state of the whole bank
	always_comb begin
		st_next           = st_reg;
		st_next.up_s1     = IS_UPSTREAM_I;
		st_next.up_s2     = st_reg.up_s1;
		st_next.rvalid    = 1'b0;
		st_next.cfg_reset = 1'b0;

		// port role strap caught after release; sets the rate-change default
		if (st_reg.strap_cnt != 2'h0) begin
			st_next.strap_cnt = st_reg.strap_cnt - 2'h1;
			if (st_reg.strap_cnt == 2'h1) begin
				st_next.is_up                     = st_reg.up_s2;
				st_next.rate_rst[`BIT_RATE_CHANGE] = st_reg.up_s2; // [RULE6]
			end
		end

		// software writes touch only the writable fields
		if (cfg_ok) begin
			unique case (CFG_ADDR_I)
				`OFS_TUNE_A: begin
					st_next.tune_a = (st_reg.tune_a & ~be_mask) | (CFG_WDATA_I & be_mask); // [RULE2]
				end
				`OFS_RATE_RST: begin
					// bits 29:0 stay read-only
					st_next.rate_rst = (st_reg.rate_rst & ~(be_mask & `WMASK_RATE_RST))
						| (CFG_WDATA_I & be_mask & `WMASK_RATE_RST); // [RULE4] [RULE6]
				end
				`OFS_TL_OPT: begin
					// overpass and ordering bits settable from the upstream port only
					if (st_reg.is_up) begin
						st_next.tl_opt = (st_reg.tl_opt & ~(be_mask & `WMASK_TL_OPT))
							| (CFG_WDATA_I & be_mask & `WMASK_TL_OPT); // [RULE7] [RULE8] [RULE9]
					end
				end
				default: begin
				end
			endcase
		end

		// preload overrides each field's default, read-only ones included, except ordering disable when not from eeprom
		if (PRE_WR_I) begin
			unique case (PRE_ADDR_I)
				`OFS_TUNE_A:   st_next.tune_a = PRE_WDATA_I; // [RULE1]
				`OFS_TUNE_B:   st_next.tune_b = PRE_WDATA_I; // [RULE1]
				`OFS_RATE_RST: st_next.rate_rst = PRE_WDATA_I; // [RULE1]
				`OFS_TL_OPT: begin
					// ordering disable only takes an eeprom default
					if (PRE_SRC_I == port_tuning_pkg::SRC_EEPROM) begin
						st_next.tl_opt = PRE_WDATA_I & ~`RSVD_TL_OPT; // [RULE1] [RULE14]
					end else begin
						st_next.tl_opt = ((PRE_WDATA_I & ~`PRE_ONLY_EEPROM)
							| (st_next.tl_opt & `PRE_ONLY_EEPROM)) & ~`RSVD_TL_OPT; // [RULE9]
					end
				end
				default: begin
				end
			endcase
		end

		// upstream link down restores writable config unless kept
		if (UP_LINK_DOWN_I && !st_reg.rate_rst[`BIT_KEEP_CFG]) begin
			st_next.tune_a                       = `RST_TUNE_A; // [RULE5]
			st_next.rate_rst[`BIT_RATE_CHANGE]    = st_reg.is_up;
			st_next.rate_rst[`BIT_GEN1_ONLY]      = 1'b0;
			st_next.tl_opt[`BIT_MW_OVERPASS]      = 1'b0;
			st_next.tl_opt[`BIT_ORDER_DISABLE]    = 1'b0;
			st_next.cfg_reset                    = 1'b1; // [RULE5]
		end

		// read data one cycle after the request; unmapped reads zero
		if (CFG_RD_I) begin
			st_next.rvalid = 1'b1;
			unique case (CFG_ADDR_I)
				`OFS_TUNE_A:   st_next.rdata = st_reg.tune_a;
				`OFS_TUNE_B:   st_next.rdata = st_reg.is_up ? st_reg.tune_b : 32'h0000_0000; // [RULE3]
				`OFS_RATE_RST: st_next.rdata = st_reg.rate_rst;
				`OFS_TL_OPT:   st_next.rdata = st_reg.tl_opt & ~`RSVD_TL_OPT; // [RULE14]
				default:       st_next.rdata = 32'h0000_0000;
			endcase
		end

		// reset select registered so the pin comes straight off a flop
		st_next.reset_sel = st_next.tl_opt[`BIT_RESET_SELECT] & st_next.is_up; // [RULE12]
	end

	// one register stage for the whole bank
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_reg.tune_a    <= `RST_TUNE_A; // [RULE2]
			st_reg.tune_b    <= `RST_TUNE_B; // [RULE3]
			st_reg.rate_rst  <= `RST_RATE_RST; // [RULE4]
			st_reg.tl_opt    <= `RST_TL_OPT; // [RULE7]
			st_reg.up_s1     <= 1'b0;
			st_reg.up_s2     <= 1'b0;
			st_reg.is_up     <= 1'b0;
			st_reg.strap_cnt <= `STRAP_WAIT;
			st_reg.rdata     <= 32'h0000_0000;
			st_reg.rvalid    <= 1'b0;
			st_reg.cfg_reset <= 1'b0;
			st_reg.reset_sel <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs are bits of the state flops
	assign CFG_RDATA_O              = st_reg.rdata;
	assign CFG_RVALID_O             = st_reg.rvalid;
	assign CFG_DATA_RESET_O         = st_reg.cfg_reset;
	assign RATE_CHANGE_CONTROL_O    = st_reg.rate_rst[`BIT_RATE_CHANGE];
	assign FIRST_GEN_ONLY_O         = st_reg.rate_rst[`BIT_GEN1_ONLY];
	assign WRITE_OVERPASS_DISABLE_O = st_reg.tl_opt[`BIT_MW_OVERPASS]; // [RULE8]
	assign RELAXED_ORDER_DISABLE_O  = st_reg.tl_opt[`BIT_ORDER_DISABLE]; // [RULE9]
	assign RATE_CHANGE_ATTEMPTS_O   = st_reg.tl_opt[`LSB_ATTEMPTS +: 2]; // [RULE10]
	assign PORT_DISABLE_O           = st_reg.tl_opt[`BIT_PORT_DISABLE]; // [RULE11]
	// downstream ports have no use for the reset select
	assign RESET_SELECT_O           = st_reg.reset_sel; // [RULE12]
	assign PHY_RETRAIN_DISABLE_O    = st_reg.tl_opt[`LSB_RETRAIN_MIRROR]; // [RULE13]

	// checks on the bank's own behaviour
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);

	sequence s_full_write_a;
		cfg_ok && CFG_ADDR_I == `OFS_TUNE_A && CFG_BE_I == 4'hF && !PRE_WR_I;
	endsequence

	sequence s_quiet_a;
		!cfg_ok && !PRE_WR_I && !UP_LINK_DOWN_I;
	endsequence

	property p_tune_a_write;
		s_full_write_a ##0 !UP_LINK_DOWN_I |=> st_reg.tune_a == $past(CFG_WDATA_I);
	endproperty
	a_tune_a_write: assert property (p_tune_a_write) else $error("tune_a write lost"); // [RULE2]

	property p_tune_b_ro;
		cfg_ok && !PRE_WR_I |=> $stable(st_reg.tune_b);
	endproperty
	a_tune_b_ro: assert property (p_tune_b_ro) else $error("tune_b changed by config"); // [RULE3]

	property p_tune_b_down_zero;
		CFG_RD_I && CFG_ADDR_I == `OFS_TUNE_B && !st_reg.is_up |=> CFG_RDATA_O == 32'h0000_0000;
	endproperty
	a_tune_b_down_zero: assert property (p_tune_b_down_zero) else $error("tune_b seen downstream"); // [RULE3]

	property p_rate_low_ro;
		cfg_ok && !PRE_WR_I |=> st_reg.rate_rst[29:0] == $past(st_reg.rate_rst[29:0]);
	endproperty
	a_rate_low_ro: assert property (p_rate_low_ro) else $error("read-only field written"); // [RULE4]

	property p_link_down_reset;
		UP_LINK_DOWN_I && !st_reg.rate_rst[`BIT_KEEP_CFG]
			|=> CFG_DATA_RESET_O && st_reg.tune_a == `RST_TUNE_A
			##1 (!CFG_DATA_RESET_O || $past(UP_LINK_DOWN_I));
	endproperty
	a_link_down_reset: assert property (p_link_down_reset) else $error("link-down reset missing"); // [RULE5]

	property p_link_down_keep;
		s_quiet_a or (UP_LINK_DOWN_I && st_reg.rate_rst[`BIT_KEEP_CFG] && !cfg_ok && !PRE_WR_I)
			|=> $stable(st_reg.tune_a) && !CFG_DATA_RESET_O;
	endproperty
	a_link_down_keep: assert property (p_link_down_keep) else $error("config lost while kept"); // [RULE5]

	property p_strap_default;
		st_reg.strap_cnt == 2'h1 |=> st_reg.rate_rst[`BIT_RATE_CHANGE] == st_reg.is_up
			&& st_reg.strap_cnt == 2'h0;
	endproperty
	a_strap_default: assert property (p_strap_default) else $error("rate change default wrong"); // [RULE6]

	property p_overpass_up_only;
		cfg_ok && CFG_ADDR_I == `OFS_TL_OPT && !st_reg.is_up && !PRE_WR_I && !UP_LINK_DOWN_I
			|=> $stable(st_reg.tl_opt[`BIT_MW_OVERPASS]);
	endproperty
	a_overpass_up_only: assert property (p_overpass_up_only) else $error("overpass set downstream"); // [RULE8]

	property p_order_eeprom_only;
		PRE_WR_I && PRE_ADDR_I == `OFS_TL_OPT && PRE_SRC_I != port_tuning_pkg::SRC_EEPROM
			&& !cfg_ok && !UP_LINK_DOWN_I |=> $stable(st_reg.tl_opt[`BIT_ORDER_DISABLE]);
	endproperty
	a_order_eeprom_only: assert property (p_order_eeprom_only) else $error("order bit preloaded"); // [RULE9]

	property p_retrain_preload;
		PRE_WR_I && PRE_ADDR_I == `OFS_TL_OPT
			|=> PHY_RETRAIN_DISABLE_O == $past(PRE_WDATA_I[`LSB_RETRAIN_MIRROR]);
	endproperty
	a_retrain_preload: assert property (p_retrain_preload) else $error("retrain mirror wrong"); // [RULE13]

	property p_reserved_zero;
		(st_reg.tl_opt & `RSVD_TL_OPT) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [RULE14]

	property p_read_answer;
		CFG_RD_I |=> CFG_RVALID_O ##1 (!CFG_RVALID_O || $past(CFG_RD_I));
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer timing wrong");

endmodule : switch_port_tuning_csr_bank

`default_nettype wire

/* verif/preload_master_model.sv */
// preload master model: replaces register defaults one word per pulse
`timescale 1ns/1ps
`default_nettype none

module preload_master_model (
	input  wire logic        clk_i,
	output logic             pre_wr_o,
	output logic [1:0]       pre_src_o,
	output logic [7:0]       pre_addr_o,
	output logic [31:0]      pre_wdata_o
);
	// idle lines at time zero
	initial begin
		pre_wr_o    = 1'b0;
		pre_src_o   = 2'h0;
		pre_addr_o  = 8'h00;
		pre_wdata_o = 32'h0000_0000;
	end

	// one word per pulse; lines inverted after release so stale data never looks valid
	task automatic load(input logic [1:0] src, input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk_i);
		pre_wr_o    <= 1'b1;
		pre_src_o   <= src;
		pre_addr_o  <= addr;
		pre_wdata_o <= data;
		@(posedge clk_i);
		pre_wr_o    <= 1'b0;
		pre_src_o   <= ~src;
		pre_addr_o  <= ~addr;
		pre_wdata_o <= ~data;
	endtask : load
endmodule : preload_master_model
`default_nettype wire

/* verif/switch_port_tuning_csr_bank_test.sv */
// self-checking bench of the port tuning register bank
`timescale 1ns/1ps
`default_nettype none
`include "port_tuning_regs.svh"

module switch_port_tuning_csr_bank_test;
	logic        clk = 1'b0, nrst = 1'b0, up = 1'b1, ldn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  be = 4'h0;
	logic        pwr;
	logic [1:0]  psrc;
	logic [7:0]  paddr;
	logic [31:0] pdata, rdata;
	logic        rvalid, dreset, rcc, g1, wod, rod, pdis, rsel, rtd;
	logic [1:0]  att;
	int          bad_count = 0, compares = 0, cycles = 0;

	always #12.5 clk = ~clk;

	preload_master_model pm (.clk_i(clk), .pre_wr_o(pwr), .pre_src_o(psrc),
		.pre_addr_o(paddr), .pre_wdata_o(pdata));

	switch_port_tuning_csr_bank uut (.REF_CLK_I(clk), .NRST_I(nrst), .IS_UPSTREAM_I(up),
		.UP_LINK_DOWN_I(ldn), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr),
		.CFG_WDATA_I(wdata), .CFG_BE_I(be), .PRE_WR_I(pwr), .PRE_SRC_I(psrc),
		.PRE_ADDR_I(paddr), .PRE_WDATA_I(pdata), .CFG_RDATA_O(rdata),
		.CFG_RVALID_O(rvalid), .CFG_DATA_RESET_O(dreset), .RATE_CHANGE_CONTROL_O(rcc),
		.FIRST_GEN_ONLY_O(g1), .WRITE_OVERPASS_DISABLE_O(wod), .RELAXED_ORDER_DISABLE_O(rod),
		.RATE_CHANGE_ATTEMPTS_O(att), .PORT_DISABLE_O(pdis), .RESET_SELECT_O(rsel),
		.PHY_RETRAIN_DISABLE_O(rtd));

	task automatic conclude();
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	// hang guard, well above the roughly 126 cycles the tests need
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// strap held through the whole reset and the sync edges after it
	task automatic do_reset(input logic role);
		@(posedge clk);
		nrst <= 1'b0;
		up   <= role;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : do_reset

	task automatic cw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		be    <= b;
		@(posedge clk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask : cw

	// answer lands one cycle after the request edge
	task automatic cr(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rvalid, 1);
		chk(rdata, exp);
	endtask : cr

	task automatic pulse_link_down(input logic exp);
		@(posedge clk);
		ldn <= 1'b1;
		@(posedge clk);
		ldn <= 1'b0;
		#1;
		chk(dreset, exp);
	endtask : pulse_link_down

	task automatic t_reset_values();
		cr(`OFS_TUNE_A, 32'h000F_0000);
		cr(`OFS_TUNE_B, 32'h0000_0000);
		cr(`OFS_RATE_RST, 32'h7308_3333);
		cr(`OFS_TL_OPT, 32'h0079_1894);
		chk({rcc, rsel, rtd, pdis, att}, 32'h0000_0038);
	endtask : t_reset_values

	task automatic t_writes();
		cw(`OFS_TUNE_A, 32'hA5A5_5A5A, 4'hF);
		cr(`OFS_TUNE_A, 32'hA5A5_5A5A);
		cw(`OFS_TUNE_A, 32'h0000_00C3, 4'h1);
		cr(`OFS_TUNE_A, 32'hA5A5_5AC3);
		cw(`OFS_TUNE_B, 32'hFFFF_FFFF, 4'hF);
		cr(`OFS_TUNE_B, 32'h0000_0000);
		cw(`OFS_RATE_RST, 32'hFFFF_FFFF, 4'hF);
		cr(`OFS_RATE_RST, 32'hF308_3333);
		cw(`OFS_TL_OPT, 32'hFFFF_FFFF, 4'hF);
		cr(`OFS_TL_OPT, 32'h0079_18F4);
		chk({g1, wod, rod}, 32'h0000_0007);
		cr(8'h90, 32'h0000_0000);
	endtask : t_writes

	// order bit held 1 by the write above: of the preload sources only the eeprom may move it
	task automatic t_preload();
		pm.load(port_tuning_pkg::SRC_SMBUS, `OFS_TL_OPT, 32'h0000_0000);
		cr(`OFS_TL_OPT, 32'h0000_0040);
		pm.load(port_tuning_pkg::SRC_EEPROM, `OFS_TL_OPT, 32'h0000_0000);
		cr(`OFS_TL_OPT, 32'h0000_0000);
		chk({rtd, rod, wod, att, pdis, rsel}, 32'h0000_0000);
		pm.load(port_tuning_pkg::SRC_I2C, `OFS_TL_OPT, 32'hFFFF_FFFF);
		cr(`OFS_TL_OPT, 32'hBFFF_1FBF);
		chk({att, pdis, rsel, rtd, rod}, 32'h0000_003E);
	endtask : t_preload

	task automatic t_link_down();
		pm.load(port_tuning_pkg::SRC_I2C, `OFS_RATE_RST, 32'h0000_0000);
		pm.load(port_tuning_pkg::SRC_SMBUS, `OFS_TUNE_A, 32'h1234_5678);
		pulse_link_down(1'b1);
		cr(`OFS_TUNE_A, 32'h000F_0000);
		cr(`OFS_RATE_RST, 32'h4000_0000);
		cr(`OFS_TL_OPT, 32'hBFFF_1F9F);
		pm.load(port_tuning_pkg::SRC_EEPROM, `OFS_RATE_RST, 32'h0000_0800);
		pm.load(port_tuning_pkg::SRC_EEPROM, `OFS_TUNE_A, 32'h1234_5678);
		pulse_link_down(1'b0);
		cr(`OFS_TUNE_A, 32'h1234_5678);
	endtask : t_link_down

	task automatic t_downstream();
		do_reset(1'b0);
		cr(`OFS_RATE_RST, 32'h3308_3333);
		pm.load(port_tuning_pkg::SRC_EEPROM, `OFS_TUNE_B, 32'h1111_1111);
		cr(`OFS_TUNE_B, 32'h0000_0000);
		cw(`OFS_TL_OPT, 32'hFFFF_FFFF, 4'hF);
		cr(`OFS_TL_OPT, 32'h0079_1894);
		chk({rcc, rsel, wod}, 32'h0000_0000);
	endtask : t_downstream

	initial begin
		do_reset(1'b1);
		t_reset_values();
		t_writes();
		t_preload();
		t_link_down();
		t_downstream();
		conclude();
	end
endmodule : switch_port_tuning_csr_bank_test
`default_nettype wire
